// ### verilog/microsecond_interval_timer.sv
// Overview of operation
// - counter adds one per tick while running
// - carry out of bit 31 loads reload value
// - overflow requests level 24 interrupt if enabled and pending was not already set
// - reload register write-only, keeps value after load
// - reload writes accepted at any time
// - overflow with pending set and not being cleared in that cycle records missed tick
// - writing one clears error, never sets it
// - overflow sets pending; write one clears it
// - interrupt on rising enable-and-pending, incl. late enable
// - single-step write advances stopped counter by one
// - transfer write copies reload into counter now
// - run bit gates automatic counting
// - reset clears enable and run bits
module microsecond_interval_timer (
  input  wire logic        clk_sys,         // system clock, 100 MHz
  input  wire logic        sys_rst,         // synchronous reset, active high
  input  wire logic        priv_reg_write,  // one-cycle write strobe
  input  wire logic        priv_reg_read,   // one-cycle read strobe
  input  wire logic [1:0]  reg_sel,         // register select code
  input  wire logic [31:0] wr_data,         // write data
  output logic      [31:0] rd_data,         // read data, held until next read
  output logic             rd_valid,        // one-cycle pulse with read data
  output logic             tick_irq,        // one-cycle interrupt request pulse
  output logic      [4:0]  interrupt_priority_level  // level of the request
);

  // microsecond tick from the prescaler
  logic us_tick;  // one cycle in every hundred

  // architectural state
  logic [31:0] interval_counter_reg;       // running count
  logic [31:0] interval_reload_value_reg;  // value loaded on overflow
  logic        run_reg;                    // counting control
  logic        tick_irq_allow_reg;         // interrupt enable
  logic        pend_reg;                   // tick pending flag
  logic        err_reg;                    // missed-tick error flag
  logic        req_level_reg;              // enable and pending, last cycle

  // decoded write strobes
  logic wr_counter;   // write to interval_counter
  logic wr_reload;    // write to interval_reload_value
  logic wr_ctl;       // write to interval_control_status
  logic step_now;     // single_step_increment request honoured
  logic force_reload; // transfer request
  logic clr_pend;     // write one to pending position
  logic clr_err;      // write one to error position
  logic advance;      // counter increments this cycle
  logic overflow;     // increment carried out of bit 31
  logic [32:0] inc_sum;        // counter plus one with carry
  logic [31:0] counter_next;   // next counter value
  logic        pend_next;      // next pending flag
  logic        err_next;       // next error flag
  logic [31:0] ctl_view;       // read view of control/status

  // tick source; it runs even while counting is stopped, so a restart
  // lands partway through a microsecond and the first step comes early
  us_prescaler i_us_prescaler (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .us_tick (us_tick)
  );

  // register select decode
  // the unmapped code decodes to no write at all
  always_comb begin
    wr_counter = priv_reg_write && (reg_sel == interval_timer_pkg::SEL_COUNTER);
    wr_reload  = priv_reg_write && (reg_sel == interval_timer_pkg::SEL_RELOAD);
    wr_ctl     = priv_reg_write && (reg_sel == interval_timer_pkg::SEL_CTL);
  end

  // control write side effects; the single step is only honoured while stopped,
  // judged on the run bit as it stands before this write takes effect
  always_comb begin
    step_now     = wr_ctl && wr_data[interval_timer_pkg::BIT_SGL] && !run_reg;
    force_reload = wr_ctl && wr_data[interval_timer_pkg::BIT_XFR];
    clr_pend     = wr_ctl && wr_data[interval_timer_pkg::BIT_PEND];
    clr_err      = wr_ctl && wr_data[interval_timer_pkg::BIT_ERR];
  end

  // increment source: running ticks or a single step
  always_comb begin
    advance  = (run_reg && us_tick) || step_now;
    inc_sum  = {1'b0, interval_counter_reg} + 33'h0_0000_0001;
    overflow = advance && inc_sum[32];
  end

  // next counter value; a direct write wins, then a transfer, then counting
  always_comb begin
    // a transfer and a step in one write: the transfer wins, the step is lost
    if (wr_counter) begin
      counter_next = wr_data;
    end else if (force_reload) begin
      counter_next = interval_reload_value_reg;
    end else if (overflow) begin
      // load the interval in place of the wrapped zero
      counter_next = interval_reload_value_reg;
    end else if (advance) begin
      counter_next = inc_sum[31:0];
    end else begin
      counter_next = interval_counter_reg;
    end
  end

  // counter register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      interval_counter_reg <= interval_timer_pkg::COUNTER_RST;
    end else begin
      interval_counter_reg <= counter_next;
    end
  end

  // reload register: written at any time, never disturbed by a load
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      interval_reload_value_reg <= interval_timer_pkg::RELOAD_RST;
    end else if (wr_reload) begin
      interval_reload_value_reg <= wr_data;
    end
  end

  // run and enable bits; plain read/write fields cleared by reset
  // the step and transfer bits are strobes only and are never stored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_reg            <= 1'b0;
      tick_irq_allow_reg <= 1'b0;
    end else if (wr_ctl) begin
      run_reg            <= wr_data[interval_timer_pkg::BIT_RUN];
      tick_irq_allow_reg <= wr_data[interval_timer_pkg::BIT_IE];
    end
  end

  // pending and error flags; hardware set beats software clear
  always_comb begin
    if (overflow) begin
      pend_next = 1'b1;
    end else if (clr_pend) begin
      pend_next = 1'b0;
    end else begin
      pend_next = pend_reg;
    end
    // a tick is only missed if the pending flag is not being cleared now
    if (overflow && pend_reg && !clr_pend) begin
      err_next = 1'b1;
    end else if (clr_err) begin
      err_next = 1'b0;
    end else begin
      err_next = err_reg;
    end
  end

  // flag registers; cleared at reset to keep the read view defined
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      err_reg  <= err_next;
    end
  end

  // interrupt on each rising edge of enable-and-pending; an edge detector
  // rather than an overflow pulse, so a late enable still interrupts
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_level_reg <= 1'b0;
      tick_irq      <= 1'b0;
    end else begin
      req_level_reg <= tick_irq_allow_reg && pend_reg;
      tick_irq      <= tick_irq_allow_reg && pend_reg && !req_level_reg;
    end
  end

  // request level is fixed; held in a flop so the output is registered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      interrupt_priority_level <= 5'h00;
    end else begin
      interrupt_priority_level <= interval_timer_pkg::TICK_IPL;
    end
  end

  // control/status read view; write-only and unused bits read as zero
  always_comb begin
    ctl_view                                = 32'h0000_0000;
    ctl_view[interval_timer_pkg::BIT_ERR]  = err_reg;
    ctl_view[interval_timer_pkg::BIT_PEND] = pend_reg;
    ctl_view[interval_timer_pkg::BIT_IE]   = tick_irq_allow_reg;
    ctl_view[interval_timer_pkg::BIT_RUN]  = run_reg;
  end

  // read port; the reload register is write-only and returns zero,
  // as does the unused select code
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data  <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= priv_reg_read;
      if (priv_reg_read) begin
        unique case (reg_sel)
          interval_timer_pkg::SEL_COUNTER: begin
            rd_data <= interval_counter_reg;
          end
          interval_timer_pkg::SEL_CTL: begin
            rd_data <= ctl_view;
          end
          default: begin
            rd_data <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule

// ### verilog/interval_timer_pkg.sv
package interval_timer_pkg;

  // clock and microsecond tick timing
  localparam int CLK_PERIOD_NS  = 10;    // system clock period in ns
  localparam int TICK_PERIOD_NS = 1000;  // one microsecond in ns
  // cycles per tick, rounded down; never below one
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_W     = 7;     // width of the prescaler counter

  // register data width
  localparam int DATA_W = 32;

  // privileged register select codes
  localparam logic [1:0] SEL_COUNTER = 2'h0;  // interval_counter
  localparam logic [1:0] SEL_RELOAD  = 2'h1;  // interval_reload_value
  localparam logic [1:0] SEL_CTL     = 2'h2;  // interval_control_status

  // interval_control_status field positions
  localparam int BIT_ERR  = 31;  // missed-tick error
  localparam int BIT_PEND = 7;   // tick pending
  localparam int BIT_IE   = 6;   // tick_irq_allow
  localparam int BIT_SGL  = 5;   // single_step_increment, write-only
  localparam int BIT_XFR  = 4;   // force_reload, write-only
  localparam int BIT_RUN  = 0;   // counting control

  // reset values
  localparam logic [31:0] COUNTER_RST = 32'h0000_0000;  // counter after reset
  localparam logic [31:0] RELOAD_RST  = 32'h0000_0000;  // reload after reset

  // interrupt_priority_level of the tick request
  localparam logic [4:0] TICK_IPL = 5'h18;  // level 24

endpackage

// ### verilog/us_prescaler.sv
// divides the system clock down to a one-cycle microsecond tick
module us_prescaler (
  input  wire logic clk_sys,   // system clock
  input  wire logic sys_rst,   // synchronous reset, active high
  output logic      us_tick    // one-cycle pulse every microsecond
);

  logic [interval_timer_pkg::PRESCALE_W-1:0] div_reg;  // cycle count within a microsecond

  // free-running divider; it never stops, so tick spacing stays exact
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_reg <= '0;
      us_tick <= 1'b0;
    end else if (div_reg ==
                 interval_timer_pkg::PRESCALE_W'(interval_timer_pkg::TICK_CYCLES - 1)) begin
      div_reg <= '0;
      us_tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      us_tick <= 1'b0;
    end
  end

endmodule

// ### tb/timer_checker.sv
module timer_checker (
  input wire logic        clk_sys,                  // clock
  input wire logic        sys_rst,                  // reset
  input wire logic        priv_reg_write,           // write strobe
  input wire logic        priv_reg_read,            // read strobe
  input wire logic [1:0]  reg_sel,                  // select
  input wire logic [31:0] wr_data,                  // write data
  input wire logic [31:0] rd_data,                  // read data
  input wire logic        rd_valid,                 // read done
  input wire logic        tick_irq,                 // request
  input wire logic [4:0]  interrupt_priority_level  // level
);
  // all properties on the system clock, quiet while reset is held
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // every read strobe is answered on the next cycle
  property p_rd_valid; priv_reg_read |=> rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  // read data must stand between answers
  property p_rd_hold; !rd_valid |-> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_irq_pulse; tick_irq |=> !tick_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("request too long");
  // the request always carries the fixed priority level
  property p_irq_level; tick_irq |-> interrupt_priority_level == 5'h18; endproperty
  a_irq_level: assert property (p_irq_level) else $error("bad level");
  // reload and unmapped codes are both odd and read as zero
  property p_wo_read; priv_reg_read && reg_sel[0] |=> rd_data == 32'h0; endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only leaked");
  // strobe bits and unused bits of control/status read as zero
  property p_ctl_zero;
    $past(priv_reg_read && reg_sel == 2'h2) |-> (rd_data & 32'h7FFF_FF3E) == 32'h0;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("ctl bits leaked");
  // a tick may land in between, so one step of slack
  property p_cnt_rw;
    priv_reg_write && reg_sel == 2'h0 && wr_data < 32'hFFFF_FFF0 ##1 !priv_reg_write
    ##1 priv_reg_read && reg_sel == 2'h0 && !priv_reg_write
    |=> rd_data - $past(wr_data, 3) <= 32'h1;
  endproperty
  a_cnt_rw: assert property (p_cnt_rw) else $error("counter lost write");
  // a written enable reads back
  property p_ctl_en;
    priv_reg_write && reg_sel == 2'h2 && wr_data[6] ##1 !priv_reg_write
    ##1 priv_reg_read && reg_sel == 2'h2 && !priv_reg_write |=> rd_data[6];
  endproperty
  a_ctl_en: assert property (p_ctl_en) else $error("enable lost");
  // no request and no answer straight out of reset
  property p_boot; $past(sys_rst) |-> !tick_irq && !rd_valid; endproperty
  a_boot: assert property (p_boot) else $error("output after reset");
  c_irq: cover property (tick_irq);
  c_step: cover property (priv_reg_write && reg_sel == 2'h2 && wr_data[5]);
  c_err: cover property (rd_valid && rd_data[31]);
endmodule
bind microsecond_interval_timer timer_checker i_timer_checker (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .priv_reg_write(priv_reg_write), .priv_reg_read(priv_reg_read),
  .reg_sel(reg_sel), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
  .tick_irq(tick_irq), .interrupt_priority_level(interrupt_priority_level));

// ### tb/test_microsecond_interval_timer.sv
module test_microsecond_interval_timer;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, sys_rst, priv_reg_write, priv_reg_read, rd_valid, tick_irq;
  logic [1:0]  reg_sel;      // select
  logic [31:0] wr_data, rd_data, v, a;
  logic [4:0]  lvl, level;   // level seen at last request
  int          fails, total_checks, irqs, n;
  microsecond_interval_timer i_microsecond_interval_timer (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .priv_reg_write(priv_reg_write), .priv_reg_read(priv_reg_read),
    .reg_sel(reg_sel), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .tick_irq(tick_irq), .interrupt_priority_level(level));
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // count requests and keep their level
  always @(posedge clk_sys) if (tick_irq === 1'h1) begin
    irqs++;
    lvl = level;
  end
  task automatic results();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    @(posedge clk_sys);
    priv_reg_write <= 1'h1;
    reg_sel <= s;
    wr_data <= d;
    @(posedge clk_sys);
    priv_reg_write <= 1'h0;
  endtask
  // answer is due exactly one cycle after the strobe is taken
  task automatic rdc(input logic [1:0] s, output logic [31:0] d);
    @(posedge clk_sys);
    priv_reg_read <= 1'h1;
    reg_sel <= s;
    @(posedge clk_sys);
    priv_reg_read <= 1'h0;
    #1;
    if (rd_valid !== 1'h1) begin
      fails++;
      results();
    end else begin
      d = rd_data;
    end
  endtask
  // boot state, write-only reload and the unmapped code
  task automatic t_boot();
    rdc(2'h2, v);
    chk("ctl boot", 32'h0, v);
    wr(2'h1, 32'h1234_5678);
    rdc(2'h1, v);
    chk("reload read", 32'h0, v);
    rdc(2'h3, v);
    chk("unmapped", 32'h0, v);
    $display("boot done");
  endtask
  // direct counter write and one single step while stopped
  task automatic t_step();
    wr(2'h0, 32'h5);
    rdc(2'h0, v);
    chk("cnt", 32'h5, v);
    wr(2'h2, 32'h20);
    rdc(2'h0, v);
    chk("step", 32'h6, v);
    rdc(2'h2, v);
    chk("step ctl", 32'h0, v);
    $display("step done");
  endtask
  // overflow by single steps: reload, pending, missed tick, clears, late enable
  task automatic t_wrap();
    n = irqs;
    wr(2'h1, 32'hFFFF_FFFE);
    wr(2'h2, 32'h10);
    rdc(2'h0, v);
    chk("xfr", 32'hFFFF_FFFE, v);
    repeat (2) wr(2'h2, 32'h20);
    rdc(2'h0, v);
    chk("wrap", 32'hFFFF_FFFE, v);
    rdc(2'h2, v);
    chk("pend", 32'h80, v);
    repeat (2) wr(2'h2, 32'h20);
    rdc(2'h2, v);
    chk("err", 32'h8000_0080, v);
    // both overflows came with the enable clear, so no request
    chk("no irq", n, irqs);
    wr(2'h2, 32'h8000_0000);
    rdc(2'h2, v);
    chk("err clr", 32'h80, v);
    // step to the top, then overflow in the very write that clears pending
    wr(2'h2, 32'h20);
    wr(2'h2, 32'hA0);
    rdc(2'h2, v);
    chk("clr race", 32'h80, v);
    rdc(2'h0, v);
    chk("reload kept", 32'hFFFF_FFFE, v);
    // enabling while pending is already set must still interrupt
    n = irqs;
    wr(2'h2, 32'h40);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("late irq", n + 1, irqs);
    wr(2'h2, 32'h80);
    rdc(2'h2, v);
    chk("pend clr", 32'h0, v);
    $display("wrap done");
  endtask
  // periodic setup through one interval, then stop and a late reload
  task automatic t_run();
    wr(2'h1, 32'hFFFF_FFFD);
    n = irqs;
    wr(2'h2, 32'h51);
    repeat (350) @(posedge clk_sys);
    chk("irq", n + 1, irqs);
    chk("level", 32'h18, {27'h0, lvl});
    // the next overflow is at least 500 cycles after start, well clear of this
    wr(2'h2, 32'hC1);
    rdc(2'h2, v);
    chk("run ctl", 32'h41, v);
    wr(2'h2, 32'h0);
    rdc(2'h0, a);
    repeat (250) @(posedge clk_sys);
    rdc(2'h0, v);
    chk("stopped", a, v);
    wr(2'h1, 32'h123);
    wr(2'h2, 32'h10);
    rdc(2'h0, v);
    chk("late reload", 32'h123, v);
    $display("run done");
  endtask
  // counting rate: align to a tick, then expect ten ticks in 1050 cycles
  task automatic t_rate();
    wr(2'h0, 32'h100);
    wr(2'h2, 32'h1);
    rdc(2'h0, a);
    v = a;
    n = 0;
    // polls are two cycles apart, so the tick edge is known to within two
    while (v == a && n < 80) begin
      rdc(2'h0, v);
      n++;
    end
    if (v == a) begin
      fails++;
      results();
    end
    repeat (1048) @(posedge clk_sys);
    rdc(2'h0, a);
    chk("tick rate", v + 32'hA, a);
    wr(2'h2, 32'h0);
    $display("rate done");
  endtask
  // reset in mid-run with counting and interrupts enabled
  task automatic t_reset();
    wr(2'h2, 32'h41);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rdc(2'h2, v);
    chk("reset ctl", 32'h0, v & 32'h41);
    $display("reset done");
  endtask
  initial begin
    sys_rst = 1'h1;
    priv_reg_write = 1'h0;
    priv_reg_read = 1'h0;
    reg_sel = 2'h0;
    wr_data = 32'h0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'h0;
    t_boot();
    t_step();
    t_wrap();
    t_run();
    t_rate();
    t_reset();
    results();
  end
endmodule
